// ---- core/uxs_regs.vh ----
// Constants for the USB transceiver serial interface.
// Assumes inclusion by bare name from the core design files.
`ifndef UXS_REGS_VH
`define UXS_REGS_VH

// Width of the scheme selector
`define UXS_SCHEME_W 2
// Data plus SE0, bidirectional, three wires
`define UXS_DATA_ZERO_SCHEME_BI 2'h0
// Data plus SE0, unidirectional, six wires
`define UXS_DATA_ZERO_SCHEME_UNI 2'h1
// Plus/minus, bidirectional, four wires
`define UXS_PLUS_MINUS_SCHEME_BI 2'h2
// Plus/minus, unidirectional, six wires
`define UXS_PLUS_MINUS_SCHEME_UNI 2'h3
// Scheme held after reset
`define UXS_SCHEME_RESET 2'h0

// Bit positions inside the scheme code
`define UXS_SCHEME_UNI_BIT 0
`define UXS_SCHEME_PM_BIT 1

// Idle line levels: J state on a full-speed bus
`define UXS_IDLE_DP 1'h1
`define UXS_IDLE_DM 1'h0

// Cycles the receive side stays quiet after a turnaround
`define UXS_TURN_CYCLES 2'h1

`endif

// ---- core/uxs_rx_decode.v ----
// Receive decoder: turns the pins of the selected scheme into line states.
// Assumes pins are synchronous to mclk; purely combinational, no state.
`include "uxs_regs.vh"

module uxs_rx_decode
(
    // Scheme in force
    input wire [`UXS_SCHEME_W-1:0] scheme,
    // Shared pins, input side
    input wire line_data_plus_in,
    input wire single_ended_zero_minus_in,
    // Receive-only pins of the six-wire schemes; rx_differential also feeds the plus/minus bidirectional scheme
    input wire rx_plus_buffered,
    input wire rx_minus_buffered,
    input wire rx_differential,
    // Decoded line state
    output reg dec_dp,
    output reg dec_dm,
    output reg dec_data,
    output reg dec_se0
);

    // Pick the receive sources for each scheme
    always @*
    begin
        dec_dp = `UXS_IDLE_DP;
        dec_dm = `UXS_IDLE_DM;
        dec_data = `UXS_IDLE_DP;
        dec_se0 = 1'h0;
        case (scheme)
            `UXS_DATA_ZERO_SCHEME_BI:
            begin
                dec_data = line_data_plus_in;
                dec_se0 = single_ended_zero_minus_in;
                // Rebuild both wires from data and SE0
                dec_dp = line_data_plus_in & ~single_ended_zero_minus_in;
                dec_dm = ~line_data_plus_in & ~single_ended_zero_minus_in;
            end
            `UXS_DATA_ZERO_SCHEME_UNI:
            begin
                dec_dp = rx_plus_buffered;
                dec_dm = rx_minus_buffered;
                dec_data = rx_differential;
                dec_se0 = ~rx_plus_buffered & ~rx_minus_buffered;
            end
            `UXS_PLUS_MINUS_SCHEME_BI:
            begin
                dec_dp = line_data_plus_in;
                dec_dm = single_ended_zero_minus_in;
                dec_data = rx_differential;
                dec_se0 = ~line_data_plus_in & ~single_ended_zero_minus_in;
            end
            `UXS_PLUS_MINUS_SCHEME_UNI:
            begin
                dec_dp = rx_plus_buffered;
                dec_dm = rx_minus_buffered;
                dec_data = rx_differential;
                dec_se0 = ~rx_plus_buffered & ~rx_minus_buffered;
            end
            default:
            begin
                // Unreachable code: keep idle J
                dec_se0 = 1'h0;
            end
        endcase
    end

endmodule

// ---- core/uxs_serial_if.v ----
// USB transceiver serial interface: controller side to external transceiver.
// Assumes all inputs synchronous to mclk and a static scheme selection.
// How it works
// - Four schemes: three, four, six wires
// - Enable low while sending, high receiving
// - Data-SE0 bidir: data pin both ways
// - Data-SE0 bidir: SE0 pin both ways
// - Data-SE0 unidir: pins are outputs only
// - Plus/minus bidir: D+ pin both ways
// - Plus/minus bidir: D- pin both ways
`include "uxs_regs.vh"

module uxs_serial_if
(
    // Clock and reset
    input wire mclk,
    input wire reset_n,
    // Configuration
    input wire [`UXS_SCHEME_W-1:0] scheme_select,
    // Transmit request from the controller
    input wire tx_active,
    input wire tx_dp,
    input wire tx_dm,
    // Received line state to the controller
    output reg rx_valid,
    output reg rx_dp,
    output reg rx_dm,
    output reg rx_data,
    output reg rx_se0,
    // Status
    output reg [`UXS_SCHEME_W-1:0] scheme_active,
    // Transmit enable pin
    output reg tx_output_enable_n,
    // Shared data / D+ pin
    input wire line_data_plus_in,
    output reg line_data_plus_out,
    output reg line_data_plus_oe_n,
    // Shared SE0 / D- pin
    input wire single_ended_zero_minus_in,
    output reg single_ended_zero_minus_out,
    output reg single_ended_zero_minus_oe_n,
    // Receive-only pins
    input wire rx_plus_buffered,
    input wire rx_minus_buffered,
    input wire rx_differential
);

    // One-hot link states
    localparam [1:0] ST_RECEIVE = 2'h1;
    localparam [1:0] ST_TRANSMIT = 2'h2;

    // True for the shared-pin schemes
    function is_bidir;
        input [`UXS_SCHEME_W-1:0] sch;
        begin
            is_bidir = ~sch[`UXS_SCHEME_UNI_BIT];
        end
    endfunction

    // True for the data-plus-SE0 schemes
    function is_data_zero;
        input [`UXS_SCHEME_W-1:0] sch;
        begin
            is_data_zero = ~sch[`UXS_SCHEME_PM_BIT];
        end
    endfunction

    // Current and next link state
    reg [1:0] state;
    reg [1:0] next_state;
    // Quiet count after a turnaround
    reg [1:0] quiet_cnt;
    reg [1:0] next_quiet_cnt;
    // Next pin values
    reg next_plus_out;
    reg next_minus_out;
    reg next_pin_oe_n;
    reg next_enable_n;
    // Decoded receive state
    wire dec_dp;
    wire dec_dm;
    wire dec_data;
    wire dec_se0;

    // Receive decoding for the scheme in force
    uxs_rx_decode u_rx_decode
    (
        .scheme(scheme_active),
        .line_data_plus_in(line_data_plus_in),
        .single_ended_zero_minus_in(single_ended_zero_minus_in),
        .rx_plus_buffered(rx_plus_buffered),
        .rx_minus_buffered(rx_minus_buffered),
        .rx_differential(rx_differential),
        .dec_dp(dec_dp),
        .dec_dm(dec_dm),
        .dec_data(dec_data),
        .dec_se0(dec_se0)
    );

    // Next state of the link
    always @*
    begin
        next_state = state;
        case (state)
            ST_RECEIVE:
            begin
                // Start sending on request
                if (tx_active)
                    next_state = ST_TRANSMIT;
            end
            ST_TRANSMIT:
            begin
                // Hand the lines back when done
                if (!tx_active)
                    next_state = ST_RECEIVE;
            end
            default:
            begin
                // Recover to listening
                next_state = ST_RECEIVE;
            end
        endcase
    end

    // Quiet window after the lines turn round
    // Armed while sending, so it still holds on the first listening cycle
    always @*
    begin
        next_quiet_cnt = quiet_cnt;
        if (state == ST_TRANSMIT)
            next_quiet_cnt = `UXS_TURN_CYCLES;
        else if (quiet_cnt != 2'h0)
            next_quiet_cnt = quiet_cnt - 2'h1;
    end

    // Pin values for the next cycle
    always @*
    begin
        next_enable_n = (next_state != ST_TRANSMIT);
        // Idle J while not sending
        next_plus_out = `UXS_IDLE_DP;
        next_minus_out = `UXS_IDLE_DM;
        if (next_state == ST_TRANSMIT)
        begin
            if (is_data_zero(scheme_active))
            begin
                next_plus_out = tx_dp;
                next_minus_out = ~tx_dp & ~tx_dm;
            end
            else
            begin
                next_plus_out = tx_dp;
                next_minus_out = tx_dm;
            end
        end
        if (is_bidir(scheme_active))
            next_pin_oe_n = next_enable_n;
        else
            next_pin_oe_n = 1'h0;
    end

    // State, scheme and pin registers
    always @(posedge mclk)
    begin
        if (!reset_n)
        begin
            state <= ST_RECEIVE;
            quiet_cnt <= 2'h0;
            scheme_active <= `UXS_SCHEME_RESET;
            tx_output_enable_n <= 1'h1;
            line_data_plus_out <= `UXS_IDLE_DP;
            single_ended_zero_minus_out <= `UXS_IDLE_DM;
            line_data_plus_oe_n <= 1'h1;
            single_ended_zero_minus_oe_n <= 1'h1;
        end
        else
        begin
            state <= next_state;
            quiet_cnt <= next_quiet_cnt;
            if (state == ST_RECEIVE && !tx_active)
                scheme_active <= scheme_select;
            tx_output_enable_n <= next_enable_n;
            line_data_plus_out <= next_plus_out;
            single_ended_zero_minus_out <= next_minus_out;
            line_data_plus_oe_n <= next_pin_oe_n;
            single_ended_zero_minus_oe_n <= next_pin_oe_n;
        end
    end

    // Received state, valid only while listening
    always @(posedge mclk)
    begin
        if (!reset_n)
        begin
            rx_valid <= 1'h0;
            rx_dp <= `UXS_IDLE_DP;
            rx_dm <= `UXS_IDLE_DM;
            rx_data <= `UXS_IDLE_DP;
            rx_se0 <= 1'h0;
        end
        // No sample on the edge that starts a transmit
        else if (state == ST_RECEIVE && next_state == ST_RECEIVE && tx_output_enable_n && quiet_cnt == 2'h0)
        begin
            rx_valid <= 1'h1;
            rx_dp <= dec_dp;
            rx_dm <= dec_dm;
            rx_data <= dec_data;
            rx_se0 <= dec_se0;
        end
        else
        begin
            // Hold last state, flag invalid
            rx_valid <= 1'h0;
        end
    end

endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the transceiver serial interface.
// Assumes the checker binds itself and the model stands for the transceiver.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0, reset_n = 1'b0, tx_active = 1'b0, tx_dp = 1'b0, tx_dm = 1'b0, st_dp = 1'b1, st_dm = 1'b0;
    logic [1:0] scheme_select = 2'h0;
    wire [1:0] sa;
    wire rv, rdp, rdm, rdat, rse0, en_n, dpi, dpo, dpoe, dmi, dmo, dmoe, mdp, mdm, vp1, vm1, rcv;
    integer seed = 32'hf0d4efa0, num_errors = 0, check_count = 0, r;
    logic sd, sm;
    logic [19:0] n;
    logic [19:0] q[$];
    wire [9:0] o = {en_n, dpoe, dmoe, dpo, dmo, rv, rdp, rdm, rdat, rse0};
    always #2 mclk = ~mclk;
    // Shared pins carry whoever drives them
    assign dpi = dpoe ? mdp : dpo;
    assign dmi = dmoe ? mdm : dmo;
    uxs_serial_if dut (.mclk, .reset_n, .scheme_select, .tx_active, .tx_dp, .tx_dm, .rx_valid(rv), .rx_dp(rdp),
        .rx_dm(rdm), .rx_data(rdat), .rx_se0(rse0), .scheme_active(sa), .tx_output_enable_n(en_n),
        .line_data_plus_in(dpi), .line_data_plus_out(dpo), .line_data_plus_oe_n(dpoe),
        .single_ended_zero_minus_in(dmi), .single_ended_zero_minus_out(dmo), .single_ended_zero_minus_oe_n(dmoe),
        .rx_plus_buffered(vp1), .rx_minus_buffered(vm1), .rx_differential(rcv));
    uxs_xcvr_model xcvr (.mclk, .tx_output_enable_n(en_n), .st_dp, .st_dm, .scheme(sa), .dp_pin(mdp),
        .dm_pin(mdm), .vp1, .vm1, .rcv);
    // Print counts and verdict, then stop
    task report_and_stop;
        $display("Checks %0d, mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // One cycle of stimulus; notes what the next edge must show
    task step(input logic t, d, m, a, b, input logic [9:0] e, k);
        @(negedge mclk);
        {tx_active, tx_dp, tx_dm, st_dp, st_dm} = {t, d, m, a, b};
        q.push_back({k, e});
    endtask
    // Compare each settled result with the oldest note
    always @(posedge mclk)
    begin
        #1;
        if (q.size() > 0)
        begin
            n = q.pop_front();
            check_count++;
            if ((o & n[19:10]) !== (n[9:0] & n[19:10]))
            begin
                num_errors++;
                $display("MISMATCH at %0t: got %h expected %h", $time, o & n[19:10], n[9:0] & n[19:10]);
            end
        end
    end
    // Main sequence: every scheme idles, receives, transmits
    initial
    begin
        repeat (3) @(negedge mclk);
        reset_n = 1'b1;
        for (int s = 0; s < 4; s++)
        begin
            for (int i = 0; i < 5; i++)
            begin
                step(0, 0, 0, 1, 0, 10'h200, (s > 0 && i < 2) ? 10'h210 : 10'h000);
                if (i == 1)
                    scheme_select = s[1:0];
            end
            for (int i = 0; i < 6; i++)
            begin
                r = $random(seed);
                sd = r[0];
                sm = r[1] & ~r[0];
                step(0, 0, 0, sd, sm, {1'b1, ~s[0], ~s[0], 3'b101, sd, sm, sd, ~sd & ~sm}, 10'h3ff);
            end
            for (int i = 0; i < 5; i++)
            begin
                r = $random(seed);
                step(1, r[0], r[1], 1, 0, {3'b000, r[0], s[1] ? r[1] : ~r[0] & ~r[1], 5'h00}, 10'h3f0);
            end
            $display("Scheme %0d test done", s);
        end
        step(0, 0, 0, 1, 0, 10'h200, 10'h210);
        repeat (2) @(negedge mclk);
        report_and_stop();
    end
    // Watchdog: the tests need under 100 cycles
    initial
    begin
        #2000;
        num_errors++;
        report_and_stop();
    end
endmodule

// ---- tb/uxs_serial_checker.sv ----
// Checker for the transceiver serial interface ports.
// Assumes it is bound to uxs_serial_if; one clock domain.
`include "uxs_regs.vh"
module uxs_serial_checker
(
    // All ports of the interface, seen as inputs
    input wire mclk, reset_n, tx_active, tx_dp, tx_dm, rx_valid, rx_dp, rx_dm, rx_data, rx_se0,
    input wire [`UXS_SCHEME_W-1:0] scheme_select,
    input wire [`UXS_SCHEME_W-1:0] scheme_active,
    input wire tx_output_enable_n, line_data_plus_in, line_data_plus_out, line_data_plus_oe_n,
    input wire single_ended_zero_minus_in, single_ended_zero_minus_out, single_ended_zero_minus_oe_n,
    input wire rx_plus_buffered, rx_minus_buffered, rx_differential
);
    timeunit 1ns;
    timeprecision 1ps;
    // Short aliases
    wire en_n = tx_output_enable_n;
    wire dp_oe = line_data_plus_oe_n;
    wire dm_oe = single_ended_zero_minus_oe_n;
    wire dp_o = line_data_plus_out;
    wire dm_o = single_ended_zero_minus_out;
    wire [`UXS_SCHEME_W-1:0] sa = scheme_active;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    en_low_a: assert property (tx_active |=> !en_n) else $error("enable stays high");
    en_high_a: assert property (!tx_active |=> en_n) else $error("enable stays low");
    tx_drive_a: assert property (!en_n |-> !dp_oe && !dm_oe) else $error("pins not driven");
    bi_release_a: assert property (en_n && !sa[0] && $stable(sa) |-> dp_oe && dm_oe)
        else $error("pins not released");
    ds_tx_a: assert property (!en_n && !sa[1] |-> dp_o == $past(tx_dp) && dm_o == (!$past(tx_dp) && !$past(tx_dm)))
        else $error("data-SE0 transmit wrong");
    pm_tx_a: assert property (!en_n && sa[1] |-> dp_o == $past(tx_dp) && dm_o == $past(tx_dm))
        else $error("plus/minus transmit wrong");
    rx_quiet_a: assert property (!en_n |-> !rx_valid [*3]) else $error("receive not quiet");
    rx_pm_a: assert property (rx_valid && $past(sa) == 2'h3 |-> rx_dp == $past(rx_plus_buffered))
        else $error("buffered receive wrong");
    cover property (!en_n && sa == 2'h0);
    cover property (!en_n && sa == 2'h3);
    cover property (rx_valid && sa == 2'h1);
endmodule

bind uxs_serial_if uxs_serial_checker u_chk (.*);

// ---- tb/uxs_xcvr_model.sv ----
// Transceiver model: returns line states while the device listens.
// Assumes the bench resolves shared pins from the device's enables.
module uxs_xcvr_model
(
    // Clock, enable, scheme and line state to present
    input wire mclk, tx_output_enable_n, st_dp, st_dm,
    input wire [1:0] scheme,
    // Shared pin drive and receive-only pins
    output logic dp_pin, dm_pin, vp1, vm1, rcv
);
    timeunit 1ns;
    timeprecision 1ps;
    // Filler that changes each cycle while nothing is presented
    logic tg = 1'b0;
    always @(posedge mclk) tg <= ~tg;
    always_comb
    begin
        if (tx_output_enable_n)
        begin
            dp_pin = st_dp;
            dm_pin = scheme[1] ? st_dm : (~st_dp & ~st_dm);
            {vp1, vm1, rcv} = {st_dp, st_dm, st_dp};
        end
        else
            {dp_pin, dm_pin, vp1, vm1, rcv} = {5{tg}};
    end
endmodule
